// file: include/ext_mem_regs.svh
`ifndef EXT_MEM_REGS_SVH
`define EXT_MEM_REGS_SVH
// Address value after reset
`define EXT_MEM_ADDR_RST   16'h0000
// Space select codes
`define EXT_MEM_SEL_X      1'h0
`define EXT_MEM_SEL_Y      1'h1
// Shortest access: two phases of the instruction cycle
`define EXT_MEM_MIN_CYC    2
// Strobe cycles before the synchronised wait level can reflect the strobe
`define EXT_MEM_WAIT_SETTLE 2'h2
`endif

// file: include/ext_mem_pkg.sv
package ext_mem_pkg;
  // Core-side access request
  typedef struct packed {
    logic        write;   // 1 write, 0 read
    logic        space_y; // 1 Y space, 0 X space
    logic [15:0] addr;    // Word address
    logic [15:0] wdata;   // Write data
  } mem_req_s;
  // Port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_FINISH,
    ST_HELD
  } port_state_e;
endpackage

// file: core/ext_data_mem_bus_iface.sv
// Behaviour
// - Space select low X, high Y
// - Address holds last value between accesses
// - Address zero from reset until first access
// - Sixteen-bit address and data, access only
// - Low wait input stretches read access
// - Bus owned low while device uses bus
// - Grant output low when bus handed over
// - Pins high impedance idle or granted
// - External access takes two or more cycles
`include "ext_mem_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_data_mem_bus_iface (
  input  wire logic                  sys_clk,                // 40 MHz clock
  input  wire logic                  nrst,                   // Sync reset, active low
  input  wire ext_mem_pkg::mem_req_s req,                    // Access request from core
  input  wire logic                  req_valid,              // Request present
  output logic                       req_ready,              // Request taken this cycle
  output logic                       rsp_valid,              // Access finished pulse
  output logic [15:0]                rsp_rdata,              // Read data
  output logic [15:0]                ext_mem_addr,           // Address pins
  output logic                       ext_mem_addr_oe,        // Address pin enable
  output logic                       space_sel,              // X low, Y high
  output logic                       space_sel_oe,           // Space select enable
  input  wire logic [15:0]           ext_mem_bus_in,         // Data pins, input side
  output logic [15:0]                ext_mem_bus_out,        // Data pins, output side
  output logic                       ext_mem_bus_oe,         // Data pins enable
  output logic                       read_strobe_n,          // Read strobe, active low
  output logic                       write_strobe_n,         // Write strobe, active low
  output logic                       strobe_oe,              // Strobe pin enable
  input  wire logic                  mem_wait_n,             // Wait input, low adds wait
  input  wire logic                  bus_takeover_request_n, // Hold request, active low
  output logic                       bus_grant_n,            // Hold grant, active low
  output logic                       bus_owned_n             // Bus in use, active low
);

  // Synchronisers for pin inputs; first stage feeds only the second
  logic [1:0] wait_sync_q;
  logic [1:0] hold_sync_q;
  logic       wait_n_s;          // Synchronised wait level
  logic       hold_n_s;          // Synchronised hold request level

  ext_mem_pkg::port_state_e state_q;    // Sequencer state
  ext_mem_pkg::mem_req_s    cur_q;      // Access in flight
  logic [1:0]               settle_q;   // Strobe cycles seen, saturating
  logic                     strobe_end; // Strobe phase closes at this edge

  assign wait_n_s = wait_sync_q[1];
  assign hold_n_s = hold_sync_q[1];

  // a read may close only once the wait pin, answered after the strobe
  // fell, has crossed both synchroniser stages; earlier samples are stale
  // and would end a stretched read early. Costs two cycles on every read.
  assign strobe_end = (state_q == ext_mem_pkg::ST_STROBE) &&
                      (cur_q.write ||
                       (settle_q == `EXT_MEM_WAIT_SETTLE && wait_n_s));

  // Two-stage input synchronisers; idle state is wait released, no hold
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wait_sync_q <= 2'h3;
      hold_sync_q <= 2'h3;
    end else begin
      wait_sync_q <= {wait_sync_q[0], mem_wait_n};
      hold_sync_q <= {hold_sync_q[0], bus_takeover_request_n};
    end
  end

  // Strobe-phase cycle count, cleared outside the strobe phase
  // Saturates so a long wait stretch cannot wrap it back to zero
  // and reopen the stale-sample window
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      settle_q <= 2'h0;
    end else if (state_q == ext_mem_pkg::ST_STROBE) begin
      if (settle_q != `EXT_MEM_WAIT_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
    end else begin
      settle_q <= 2'h0;
    end
  end

  // Sequencer: setup, strobe (stretched by wait), finish
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= ext_mem_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        ext_mem_pkg::ST_IDLE: begin
          // hold only between accesses; hold beats a new request
          if (!hold_n_s) begin
            state_q <= ext_mem_pkg::ST_HELD;
          end else if (req_valid) begin
            state_q <= ext_mem_pkg::ST_SETUP;
          end
        end
        // at least two cycles per access
        ext_mem_pkg::ST_SETUP: begin
          state_q <= ext_mem_pkg::ST_STROBE;
        end
        ext_mem_pkg::ST_STROBE: begin
          // reads stretch while wait is low; writes ignore it
          // and close after their single strobe cycle
          if (strobe_end) begin
            state_q <= ext_mem_pkg::ST_FINISH;
          end
        end
        ext_mem_pkg::ST_FINISH: begin
          state_q <= ext_mem_pkg::ST_IDLE;
        end
        ext_mem_pkg::ST_HELD: begin
          // resume only once request returns high
          if (hold_n_s) begin
            state_q <= ext_mem_pkg::ST_IDLE;
          end
        end
        // Unused codes of the three-bit state fall back to idle
        default: begin
          state_q <= ext_mem_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Request capture, accepted only in idle with no pending hold
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cur_q     <= '0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      if (state_q == ext_mem_pkg::ST_IDLE && hold_n_s && req_valid) begin
        cur_q     <= req;
        req_ready <= 1'b1;
      end
    end
  end

  // Address and space pins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      // address zero until the first access
      ext_mem_addr <= `EXT_MEM_ADDR_RST;
      space_sel    <= `EXT_MEM_SEL_X;
    end else if (state_q == ext_mem_pkg::ST_SETUP) begin
      // address is launched only for an access
      ext_mem_addr <= cur_q.addr;
      // space select from the target space
      space_sel    <= cur_q.space_y ? `EXT_MEM_SEL_Y : `EXT_MEM_SEL_X;
    end
    // otherwise the address keeps its last value
  end

  // Enables and strobes; pins float outside accesses and under hold
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ext_mem_addr_oe <= 1'b0;
      space_sel_oe    <= 1'b0;
      ext_mem_bus_oe  <= 1'b0;
      ext_mem_bus_out <= 16'h0000;
      strobe_oe       <= 1'b0;
      read_strobe_n   <= 1'b1;
      write_strobe_n  <= 1'b1;
      bus_owned_n     <= 1'b1;
    end else begin
      // drive only in setup and strobe phases
      // and release on the very edge that closes the access
      ext_mem_addr_oe <= (state_q == ext_mem_pkg::ST_SETUP) ||
                         (state_q == ext_mem_pkg::ST_STROBE && !strobe_end);
      space_sel_oe    <= (state_q == ext_mem_pkg::ST_SETUP) ||
                         (state_q == ext_mem_pkg::ST_STROBE && !strobe_end);
      strobe_oe       <= (state_q == ext_mem_pkg::ST_SETUP) ||
                         (state_q == ext_mem_pkg::ST_STROBE && !strobe_end);
      bus_owned_n     <= !((state_q == ext_mem_pkg::ST_SETUP) ||
                           (state_q == ext_mem_pkg::ST_STROBE && !strobe_end));
      // exactly one strobe; a read strobe stays low through the stretch
      read_strobe_n   <= !((state_q == ext_mem_pkg::ST_SETUP && !cur_q.write) ||
                           (state_q == ext_mem_pkg::ST_STROBE && !cur_q.write &&
                            !strobe_end));
      write_strobe_n  <= !(state_q == ext_mem_pkg::ST_SETUP && cur_q.write);
      // Data driven only for writes
      ext_mem_bus_oe  <= state_q == ext_mem_pkg::ST_SETUP && cur_q.write;
      ext_mem_bus_out <= cur_q.wdata;
    end
  end

  // Read data capture and completion pulse
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      // strobe_end marks the single edge at which an access closes
      if (strobe_end) begin
        rsp_valid <= 1'b1;
        if (!cur_q.write) begin
          // Sampled at the end of the strobe while memory still drives
          rsp_rdata <= ext_mem_bus_in;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= !((state_q == ext_mem_pkg::ST_IDLE && !hold_n_s) ||
                       (state_q == ext_mem_pkg::ST_HELD && !hold_n_s));
    end
  end

endmodule
`default_nettype wire

// file: test/ext_mem_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port rules seen from the pins and the core request and response handshake
module ext_mem_sva (
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire ext_mem_pkg::mem_req_s req,
  input wire logic                  req_ready,
  input wire logic                  rsp_valid,
  input wire logic [15:0]           ext_mem_addr,
  input wire logic                  ext_mem_addr_oe,
  input wire logic                  space_sel,
  input wire logic                  ext_mem_bus_oe,
  input wire logic                  read_strobe_n,
  input wire logic                  write_strobe_n,
  input wire logic                  strobe_oe,
  input wire logic                  bus_grant_n,
  input wire logic                  bus_owned_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Strobe active on the pins
  wire act = strobe_oe && !(read_strobe_n && write_strobe_n);
  sequence s_wr; !write_strobe_n ##1 rsp_valid; endsequence
  sequence s_rd; !read_strobe_n ##[1:12] rsp_valid; endsequence
  a_one_strobe: assert property (!(strobe_oe && !read_strobe_n && !write_strobe_n))
    else $error("both strobes low");
  a_grant_float: assert property (!bus_grant_n |->
    !(ext_mem_bus_oe || strobe_oe || ext_mem_addr_oe))
    else $error("pins driven in grant");
  a_addr_hold: assert property ($changed(ext_mem_addr) |-> ext_mem_addr_oe)
    else $error("address moved idle");
  a_space_addr: assert property (req_ready |=>
    space_sel == $past(req.space_y) && ext_mem_addr == $past(req.addr))
    else $error("space or address wrong");
  a_write_len: assert property (req_ready && req.write |=> s_wr)
    else $error("write timing");
  a_read_len: assert property (req_ready && !req.write |=> s_rd)
    else $error("read timing");
  a_owned_use: assert property (act |-> !bus_owned_n)
    else $error("owned high in use");
  a_grant_gap: assert property ($fell(bus_grant_n) |-> bus_owned_n && !strobe_oe)
    else $error("grant mid access");
endmodule
bind ext_data_mem_bus_iface ext_mem_sva chk_u (.sys_clk, .nrst, .req, .req_ready, .rsp_valid,
  .ext_mem_addr, .ext_mem_addr_oe, .space_sel, .ext_mem_bus_oe, .read_strobe_n,
  .write_strobe_n, .strobe_oe, .bus_grant_n, .bus_owned_n);
`default_nettype wire

// file: test/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// External data memory with a bench-set wait count
module ext_mem_model (
  input  wire logic        clk,      // System clock
  input  wire logic [3:0]  wait_cyc, // Wait cycles per read
  input  wire logic [15:0] addr,     // Address pins
  input  wire logic        space,    // X low, Y high
  input  wire logic        rd_n,     // Read strobe
  input  wire logic        wr_n,     // Write strobe
  input  wire logic        str_oe,   // Strobes driven
  input  wire logic [15:0] dout,     // Data from device
  input  wire logic        dout_oe,  // Device drives data
  output logic [15:0]      din,      // Resolved data pins
  output logic             wait_n    // Wait, low stretches
);
  logic [15:0] mem [0:131071];
  logic [15:0] last = 16'h0000;
  logic [3:0]  cnt = 4'h0;
  wire         rd = str_oe && !rd_n;
  always_comb begin
    wait_n = !(rd && cnt < wait_cyc);
    // Released lines toggle so stale data cannot pass
    din = dout_oe ? dout : rd ? mem[{space, addr}] : ~last;
  end
  always @(posedge clk) begin
    cnt <= rd ? cnt + 4'h1 : 4'h0;
    last <= din;
    if (str_oe && !wr_n) mem[{space, addr}] <= dout;
  end
endmodule
`default_nettype wire

// file: test/tb_ext_data_mem_bus_iface.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ext_data_mem_bus_iface;
  logic sys_clk, nrst, req_valid, req_ready, rsp_valid, ext_mem_addr_oe, space_sel, space_sel_oe;
  logic ext_mem_bus_oe, read_strobe_n, write_strobe_n, strobe_oe, mem_wait_n;
  logic bus_takeover_request_n, bus_grant_n, bus_owned_n;
  logic [15:0] rsp_rdata, ext_mem_addr, ext_mem_bus_in, ext_mem_bus_out;
  logic [15:0] sh [logic [16:0]];
  logic [15:0] ad [6];
  logic [3:0]  wcyc;
  ext_mem_pkg::mem_req_s req;
  int bad_count, n_tests, cyc, n;
  ext_data_mem_bus_iface dut_u (.sys_clk, .nrst, .req, .req_valid, .req_ready, .rsp_valid,
    .rsp_rdata, .ext_mem_addr, .ext_mem_addr_oe, .space_sel, .space_sel_oe, .ext_mem_bus_in,
    .ext_mem_bus_out, .ext_mem_bus_oe, .read_strobe_n, .write_strobe_n, .strobe_oe,
    .mem_wait_n, .bus_takeover_request_n, .bus_grant_n, .bus_owned_n);
  ext_mem_model mem_u (.clk(sys_clk), .wait_cyc(wcyc), .addr(ext_mem_addr), .space(space_sel),
    .rd_n(read_strobe_n), .wr_n(write_strobe_n), .str_oe(strobe_oe), .dout(ext_mem_bus_out),
    .dout_oe(ext_mem_bus_oe), .din(ext_mem_bus_in), .wait_n(mem_wait_n));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  function automatic logic [15:0] exp_rd(input logic y, input logic [15:0] a);
    return sh[{y, a}];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask
  // Bounded wait for a level, n gives cycles spent
  task automatic await(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 60) begin
      tick();
      n++;
    end
    if (n == 60) bad_count++;
  endtask
  task automatic access(input logic w, y, input logic [15:0] a, d, input logic [3:0] wt);
    int k;
    wcyc = wt;
    req = '{w, y, a, d};
    req_valid = 1'b1;
    await(req_ready, 1'b1, k);
    tick();
    req_valid = 1'b0;
    chk(ext_mem_addr, a);
    chk({15'h0, space_sel}, {15'h0, y});
    await(rsp_valid, 1'b1, k);
    if (w) sh[{y, a}] = d;
    if (w) chk(k[15:0], 16'h0001);
    else chk(rsp_rdata, exp_rd(y, a));
    if (!w) chk({15'h0, k > int'(wt)}, 16'h0001);
    tick();
    tick();
    chk(ext_mem_addr, a);
  endtask
  initial begin
    {nrst, req_valid, wcyc, req} = '0;
    bus_takeover_request_n = 1'b1;
    void'($urandom(83828));
    repeat (8) tick();
    nrst = 1'b1;
    tick();
    chk(ext_mem_addr, 16'h0000);
    chk({14'h0, bus_grant_n, bus_owned_n}, 16'h0003);
    $display("test reset done");
    ad = '{16'hffff, 16'h0000, 16'h0, 16'h0, 16'h0, 16'h0};
    for (int i = 2; i < 6; i++) ad[i] = 16'($urandom);
    // Writes then reads back, X and Y alternating, random waits
    for (int i = 0; i < 24; i++)
      access(i < 12, i[0], ad[i % 6], 16'($urandom), (i == 13) ? 4'h4 : 4'($urandom_range(0, 3)));
    $display("test traffic done");
    // master holds its request low until it is done with the bus
    bus_takeover_request_n = 1'b0;
    await(bus_grant_n, 1'b0, n);
    chk({12'h0, space_sel_oe, ext_mem_bus_oe, strobe_oe, ext_mem_addr_oe}, 16'h0000);
    req = '{1'b0, 1'b1, ad[1], 16'h0};
    req_valid = 1'b1;
    repeat (6) begin
      tick();
      chk({15'h0, req_ready}, 16'h0000);
    end
    bus_takeover_request_n = 1'b1;
    await(bus_grant_n, 1'b1, n);
    chk({15'h0, n < 6}, 16'h0001);
    access(1'b0, 1'b1, ad[1], 16'h0, 4'h0);
    access(1'b0, 1'b0, ad[0], 16'h0, 4'h2);
    $display("test hold done");
    // Mid-run reset: address pins return to zero and stay there
    nrst = 1'b0;
    repeat (3) tick();
    nrst = 1'b1;
    tick();
    chk(ext_mem_addr, 16'h0000);
    chk({14'h0, bus_grant_n, bus_owned_n}, 16'h0003);
    repeat (3) tick();
    chk(ext_mem_addr, 16'h0000);
    access(1'b1, 1'b1, ad[0], 16'($urandom), 4'h0);
    access(1'b0, 1'b1, ad[0], 16'h0, 4'h3);
    $display("test reset again done");
    print_verdict();
  end
endmodule
`default_nettype wire
